// ### inc/dfah_defines.svh
// Purpose: Shared constants for the debug flash access hold block
// Assumes: Included by its bare name
// Notes:   Offsets, field positions, codes and reset values only
`ifndef DFAH_DEFINES_SVH
`define DFAH_DEFINES_SVH

// Debugger command codes
`define DFAH_CMD_RD        2'h0
`define DFAH_CMD_WR        2'h1
`define DFAH_CMD_CTRL      2'h2

// Control word field positions
`define DFAH_CTRL_RELEASE  0
`define DFAH_CTRL_VCATCH   1

// Flash page buffer window on the system bus
`define DFAH_PGBUF_BASE    32'h0000_0000
`define DFAH_PGBUF_SIZE    32'h0000_0200

// Reset values
`define DFAH_RELEASE_RST   1'h0
`define DFAH_VCATCH_RST    1'h0

`endif

// ### inc/dfah_pkg.sv
// Purpose: Types for the debug flash access hold block
// Assumes: Nothing imported; used as dfah_pkg::name
// Notes:   Constants live in dfah_defines.svh
package dfah_pkg;

   // Power-up and hold sequence
   typedef enum logic [2:0]
   {
      ST_POR      = 3'b000,
      ST_PM_START = 3'b001,
      ST_HOLD     = 3'b010,
      ST_BOOT     = 3'b011,
      ST_RUN      = 3'b100
   } dfah_seq_t;

   // Debug access handling in the system clock domain
   typedef enum logic [1:0]
   {
      AC_IDLE = 2'b00,
      AC_BUS  = 2'b01,
      AC_RSP  = 2'b10
   } dfah_acc_t;

endpackage

// ### hdl/dfah_top.sv
// Purpose: Keeps the CPU core in reset for a debugger while the rest
//          of the system runs, and gates debug bus access to flash.
// Assumes: tck clocks the debugger clock and the debug request and answer ports; everything else on clk.
// Notes:   clk_en freezes the clk domain only; the tck side has its
//          own clock and cannot be frozen from clk.
// How it works
// - page buffer writes refused during hold
// - protected state blocks all debug bus access
// - reset pin low: slow clocks, resets held
// - tck low at release asserts core hold
// - hold keeps only core in reset
// - release bit clears hold, opens bus
// - released core loads SP, fetches vector, stalls
// - restart by pin, power cycle, bit clear with tck low
`timescale 1ns/10ps
`include "dfah_defines.svh"

module dfah_top
#(
   parameter int AW = 32,
   parameter int DW = 32
)
(
   input  wire logic          clk,          // System clock
   input  wire logic          rst,          // Async reset, high
   input  wire logic          clk_en,       // Freezes clk state when low
   input  wire logic          tck,          // Debugger clock pin
   input  wire logic          reset_n_pin,  // External reset pin, low
   input  wire logic          supply_ok,    // Internal supplies safe
   input  wire logic          protected_st, // Device protected
   input  wire logic          dbg_req,      // Debug request, tck
   input  wire logic [1:0]    dbg_cmd,      // Debug command code
   input  wire logic [AW-1:0] dbg_addr,     // Debug bus address
   input  wire logic [DW-1:0] dbg_wdata,    // Debug write data
   output logic               dbg_ready,    // Debug port can take req
   output logic               dbg_done,     // Answer pulse, tck
   output logic               dbg_err,      // Access refused
   output logic [DW-1:0]      dbg_rdata,    // Read data
   output logic               sbus_req,     // System bus request
   output logic               sbus_wr,      // System bus write
   output logic [AW-1:0]      sbus_addr,    // System bus address
   output logic [DW-1:0]      sbus_wdata,   // System bus write data
   input  wire logic          sbus_ack,     // System bus done
   input  wire logic [DW-1:0] sbus_rdata,   // System bus read data
   output logic               slow_clk_sel, // Clocks on slow clock
   output logic               sys_rst,      // Internal resets held
   output logic               dbg_port_rst, // Debug ports in reset
   output logic               cpu_hold_rst, // Core hold reset
   output logic               cpu_rst,      // Core in reset
   output logic               cpu_boot,     // Core load SP and vector
   output logic               vec_catch     // Core stalls at vector
);

   // Debug side state, tck domain
   logic          req_tgl_ff, nxt_req_tgl;
   logic [1:0]    cmd_ff, nxt_cmd;
   logic [AW-1:0] addr_ff, nxt_addr;
   logic [DW-1:0] wdata_ff, nxt_wdata;
   logic          rsp_s1_ff, rsp_s2_ff, rsp_seen_ff, nxt_rsp_seen;
   logic          done_ff, nxt_done, err_ff, nxt_err;
   logic [DW-1:0] rdata_ff, nxt_rdata;
   // Synchronisers into clk: reset pin, supply, tck level, request
   logic [3:0]    s1_ff, s2_ff;
   logic          pin_n, sup_ok, tck_lvl, req_tgl_s;
   // System side state
   dfah_pkg::dfah_seq_t seq_ff, nxt_seq;
   dfah_pkg::dfah_acc_t acc_ff, nxt_acc;
   logic          req_seen_ff, nxt_req_seen, rsp_tgl_ff, nxt_rsp_tgl;
   logic          rsp_err_ff, nxt_rsp_err, release_ff, nxt_release;
   logic [DW-1:0] rsp_rdata_ff, nxt_rsp_rdata;
   logic          vcatch_ff, nxt_vcatch, sreq_ff, nxt_sreq;
   logic          swr_ff, nxt_swr, hold;
   logic [AW-1:0] saddr_ff, nxt_saddr;
   logic [DW-1:0] swdata_ff, nxt_swdata;
   // Address falls inside the flash page buffer
   function automatic logic is_pgbuf(input logic [AW-1:0] a);
      logic [31:0] a32;
      a32 = 32'(a);
      is_pgbuf = (a32 >= `DFAH_PGBUF_BASE) &&
                 (a32 < (`DFAH_PGBUF_BASE + `DFAH_PGBUF_SIZE));
   endfunction
   // Capture a request, toggle it across, collect the answer
   always_comb
   begin
      nxt_req_tgl  = req_tgl_ff;
      nxt_cmd      = cmd_ff;
      nxt_addr     = addr_ff;
      nxt_wdata    = wdata_ff;
      nxt_rsp_seen = rsp_s2_ff;
      nxt_done     = rsp_s2_ff != rsp_seen_ff;
      nxt_err      = err_ff;
      nxt_rdata    = rdata_ff;
      if (dbg_req && dbg_ready)
      begin
         nxt_req_tgl = ~req_tgl_ff;
         nxt_cmd     = dbg_cmd;
         nxt_addr    = dbg_addr;
         nxt_wdata   = dbg_wdata;
      end
      // Answer words stay still until the next request, safe to take
      if (rsp_s2_ff != rsp_seen_ff)
      begin
         nxt_err   = rsp_err_ff;
         nxt_rdata = rsp_rdata_ff;
      end
   end
   // Debug side registers
   always_ff @(posedge tck or posedge rst)
   begin
      if (rst)
      begin
         req_tgl_ff  <= 1'h0;
         cmd_ff      <= 2'h0;
         addr_ff     <= '0;
         wdata_ff    <= '0;
         rsp_s1_ff   <= 1'h0;
         rsp_s2_ff   <= 1'h0;
         rsp_seen_ff <= 1'h0;
         done_ff     <= 1'h0;
         err_ff      <= 1'h0;
         rdata_ff    <= '0;
      end
      else
      begin
         req_tgl_ff  <= nxt_req_tgl;
         cmd_ff      <= nxt_cmd;
         addr_ff     <= nxt_addr;
         wdata_ff    <= nxt_wdata;
         rsp_s1_ff   <= rsp_tgl_ff;
         rsp_s2_ff   <= rsp_s1_ff;
         rsp_seen_ff <= nxt_rsp_seen;
         done_ff     <= nxt_done;
         err_ff      <= nxt_err;
         rdata_ff    <= nxt_rdata;
      end
   end
   // One request in flight; ready drops until its answer is back
   assign dbg_ready = (req_tgl_ff == rsp_seen_ff) && !dbg_done;
   assign dbg_done  = done_ff;
   assign dbg_err   = err_ff;
   assign dbg_rdata = rdata_ff;
   // Two-flop synchronisers for pins and the request toggle
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1_ff <= 4'h0;
         s2_ff <= 4'h0;
      end
      else if (clk_en)
      begin
         s1_ff <= {req_tgl_ff, tck, supply_ok, reset_n_pin};
         s2_ff <= s1_ff;
      end
   end

   assign {req_tgl_s, tck_lvl, sup_ok, pin_n} = s2_ff;

   // Hold sequence and debug access handling
   always_comb
   begin
      nxt_seq       = seq_ff;
      nxt_acc       = acc_ff;
      nxt_req_seen  = req_seen_ff;
      nxt_rsp_tgl   = rsp_tgl_ff;
      nxt_rsp_err   = rsp_err_ff;
      nxt_rsp_rdata = rsp_rdata_ff;
      nxt_release   = release_ff;
      nxt_vcatch    = vcatch_ff;
      nxt_sreq      = 1'h0;
      nxt_swr       = swr_ff;
      nxt_saddr     = saddr_ff;
      nxt_swdata    = swdata_ff;
      case (seq_ff)
         dfah_pkg::ST_POR:
            if (sup_ok)
               nxt_seq = dfah_pkg::ST_PM_START;
         dfah_pkg::ST_PM_START:
            if (pin_n)
               nxt_seq = tck_lvl ? dfah_pkg::ST_BOOT
                                 : dfah_pkg::ST_HOLD;
         dfah_pkg::ST_HOLD:
            if (release_ff)
               nxt_seq = dfah_pkg::ST_BOOT;
         dfah_pkg::ST_BOOT:
            nxt_seq = dfah_pkg::ST_RUN;
         dfah_pkg::ST_RUN:
            // Clearing the bit with tck low restarts; tck is looked at again
            if (!release_ff && !tck_lvl)
               nxt_seq = dfah_pkg::ST_PM_START;
         default:
            nxt_seq = dfah_pkg::ST_POR;
      endcase
      case (acc_ff)
         dfah_pkg::AC_IDLE:
            if (req_tgl_s != req_seen_ff)
            begin
               nxt_req_seen = req_tgl_s;
               nxt_rsp_err  = 1'h0;
               if (cmd_ff == `DFAH_CMD_CTRL)
               begin
                  nxt_release = wdata_ff[`DFAH_CTRL_RELEASE];
                  nxt_vcatch  = wdata_ff[`DFAH_CTRL_VCATCH];
                  nxt_acc     = dfah_pkg::AC_RSP;
               end
               else if (protected_st ||
                        seq_ff != dfah_pkg::ST_RUN ||
                        (cmd_ff == `DFAH_CMD_WR && hold &&
                         is_pgbuf(addr_ff)))
               begin
                  nxt_rsp_err = 1'h1;
                  nxt_acc     = dfah_pkg::AC_RSP;
               end
               else
               begin
                  nxt_sreq   = 1'h1;
                  nxt_swr    = cmd_ff == `DFAH_CMD_WR;
                  nxt_saddr  = addr_ff;
                  nxt_swdata = wdata_ff;
                  nxt_acc    = dfah_pkg::AC_BUS;
               end
            end
         dfah_pkg::AC_BUS:
            if (sbus_ack)
            begin
               nxt_rsp_rdata = sbus_rdata;
               nxt_acc       = dfah_pkg::AC_RSP;
            end
         dfah_pkg::AC_RSP:
         begin
            nxt_rsp_tgl = ~rsp_tgl_ff;
            nxt_acc     = dfah_pkg::AC_IDLE;
         end
         default:
            nxt_acc = dfah_pkg::AC_IDLE;
      endcase
      // Pin low or supply loss restarts the sequence
      if (!sup_ok)
         nxt_seq = dfah_pkg::ST_POR;
      else if (!pin_n)
         nxt_seq = dfah_pkg::ST_PM_START;
      if (nxt_seq == dfah_pkg::ST_POR || nxt_seq == dfah_pkg::ST_PM_START)
         nxt_release = `DFAH_RELEASE_RST;
   end

   // System side registers
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         seq_ff       <= dfah_pkg::ST_POR;
         acc_ff       <= dfah_pkg::AC_IDLE;
         req_seen_ff  <= 1'h0;
         rsp_tgl_ff   <= 1'h0;
         rsp_err_ff   <= 1'h0;
         rsp_rdata_ff <= '0;
         release_ff   <= `DFAH_RELEASE_RST;
         vcatch_ff    <= `DFAH_VCATCH_RST;
         sreq_ff      <= 1'h0;
         swr_ff       <= 1'h0;
         saddr_ff     <= '0;
         swdata_ff    <= '0;
      end
      else if (clk_en)
      begin
         seq_ff       <= nxt_seq;
         acc_ff       <= nxt_acc;
         req_seen_ff  <= nxt_req_seen;
         rsp_tgl_ff   <= nxt_rsp_tgl;
         rsp_err_ff   <= nxt_rsp_err;
         rsp_rdata_ff <= nxt_rsp_rdata;
         release_ff   <= nxt_release;
         vcatch_ff    <= nxt_vcatch;
         sreq_ff      <= nxt_sreq;
         swr_ff       <= nxt_swr;
         saddr_ff     <= nxt_saddr;
         swdata_ff    <= nxt_swdata;
      end
   end

   // Reset and clock controls decoded from the sequence state
   assign hold         = seq_ff == dfah_pkg::ST_HOLD;
   assign slow_clk_sel = seq_ff != dfah_pkg::ST_POR;
   assign sys_rst      = seq_ff == dfah_pkg::ST_POR ||
                         seq_ff == dfah_pkg::ST_PM_START;
   assign dbg_port_rst = seq_ff == dfah_pkg::ST_POR;
   assign cpu_hold_rst = hold;
   assign cpu_rst      = sys_rst || hold;
   assign cpu_boot     = seq_ff == dfah_pkg::ST_BOOT;
   assign vec_catch    = vcatch_ff;
   assign sbus_req     = sreq_ff;
   assign sbus_wr      = swr_ff;
   assign sbus_addr    = saddr_ff;
   assign sbus_wdata   = swdata_ff;

endmodule

// ### testbench/dfah_chk_asserts.sv
// Purpose: Port assertions for dfah_top
// Assumes: Bound inside dfah_top; clk and tck domains
// Notes:   Status outputs are taken as levels
`timescale 1ns/10ps
module dfah_chk
(
   input wire logic clk,          // Sys clock
   input wire logic rst,          // Reset
   input wire logic tck,          // Debug clock
   input wire logic protected_st, // Protected
   input wire logic dbg_req,      // Request
   input wire logic dbg_ready,    // Port free
   input wire logic dbg_done,     // Answer
   input wire logic sbus_req,     // Bus request
   input wire logic slow_clk_sel, // Slow clocks
   input wire logic sys_rst,      // System reset
   input wire logic dbg_port_rst, // Debug reset
   input wire logic cpu_hold_rst, // Core hold
   input wire logic cpu_rst,      // Core reset
   input wire logic cpu_boot      // Core boot
);
   // Sequence levels and bus gating, clk domain
   hold_no_bus_a: assert property (
      @(posedge clk) disable iff (rst) cpu_hold_rst |-> !sbus_req)
      else $error("bus access in hold");
   prot_no_bus_a: assert property (
      @(posedge clk) disable iff (rst)
      protected_st && $past(protected_st) |-> !sbus_req)
      else $error("bus access when protected");
   slow_clk_a: assert property (
      @(posedge clk) disable iff (rst)
      slow_clk_sel != dbg_port_rst && (sys_rst || !dbg_port_rst))
      else $error("clock or port reset level");
   hold_entry_a: assert property (
      @(posedge clk) disable iff (rst) $rose(cpu_hold_rst) |-> $past(sys_rst))
      else $error("hold entered from wrong state");
   core_only_a: assert property (
      @(posedge clk) disable iff (rst) cpu_hold_rst |-> cpu_rst && !sys_rst)
      else $error("hold resets more than core");
   release_a: assert property (
      @(posedge clk) disable iff (rst) $fell(cpu_hold_rst) |-> cpu_boot || sys_rst)
      else $error("hold left without boot");
   boot_pulse_a: assert property (
      @(posedge clk) disable iff (rst) cpu_boot |-> !cpu_rst ##1 !cpu_boot)
      else $error("boot pulse wrong");
   // Debug answer is bounded, tck domain
   dbg_answer_a: assert property (
      @(posedge tck) disable iff (rst)
      dbg_req && dbg_ready |=> !dbg_ready ##[2:60] dbg_done)
      else $error("debug request not answered");
   hold_c: cover property (@(posedge clk) $rose(cpu_hold_rst));
   boot_c: cover property (@(posedge clk) cpu_boot);
   bus_c: cover property (@(posedge clk) sbus_req);
endmodule

// ### testbench/dfah_dbg.sv
// Purpose: Debugger model driving pins and requests
// Assumes: tck runs only inside a request
// Notes:   Address and data are inverted once taken
`timescale 1ns/10ps
module dfah_dbg
(
   output logic        tck,         // Debug clock
   output logic        reset_n_pin, // Reset pin
   output logic        dbg_req,     // Request
   output logic [1:0]  dbg_cmd,     // Command
   output logic [31:0] dbg_addr,    // Address
   output logic [31:0] dbg_wdata,   // Write data
   input  wire logic   dbg_ready,   // Port free
   input  wire logic   dbg_done,    // Answer
   input  wire logic   dbg_err,     // Refused
   input  wire logic [31:0] dbg_rdata // Read data
);
   logic run = 1'b0;
   logic lvl = 1'b0;
   // Pin low from power-up; idle clock parks at strap
   initial
   begin
      reset_n_pin = 1'b0;
      dbg_req = 1'b0;
      dbg_cmd = 2'h0;
      dbg_addr = 32'h0;
      dbg_wdata = 32'h0;
      tck = 1'b0;
      #7;
      forever
         #62.5 tck = run ? ~tck : lvl;
   end
   // Strap settles before the pin moves
   task automatic strap(input logic l, input logic r);
      lvl = l;
      #200;
      reset_n_pin = r;
   endtask
   // One request; an unanswered one gives unknown
   task automatic xfer(input logic [1:0] c, input logic [31:0] a, w,
                       output logic e, output logic [31:0] d);
      int n;
      run = 1'b1;
      n = 0;
      do
         @(posedge tck) #1 n++;
      while (dbg_ready !== 1'b1 && n < 60);
      dbg_req = 1'b1;
      dbg_cmd = c;
      dbg_addr = a;
      dbg_wdata = w;
      @(posedge tck) #1 dbg_req = 1'b0;
      dbg_addr = ~a;
      dbg_wdata = ~w;
      n = 0;
      do
         @(posedge tck) #1 n++;
      while (dbg_done !== 1'b1 && n < 60);
      e = (n < 60) ? dbg_err : 1'bx;
      d = dbg_rdata;
      @(posedge tck) run = 1'b0;
   endtask
endmodule

// ### testbench/dfah_top_bench.sv
// Purpose: Self-checking bench for dfah_top
// Assumes: Debugger model drives pins and requests
// Notes:   clk_en tied high; freezing not exercised
`timescale 1ns/10ps
`include "dfah_defines.svh"
module dfah_top_bench;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        clk_en = 1'b1;
   logic        supply_ok = 1'b0;
   logic        protected_st = 1'b0;
   logic        sbus_ack = 1'b0;
   logic [31:0] sbus_rdata = 32'h0;
   logic        tck, reset_n_pin, dbg_req, dbg_ready, dbg_done, dbg_err;
   logic        sbus_req, sbus_wr, slow_clk_sel, sys_rst, dbg_port_rst;
   logic        cpu_hold_rst, cpu_rst, cpu_boot, vec_catch, seen_wr;
   logic [1:0]  dbg_cmd;
   logic [31:0] dbg_addr, dbg_wdata, dbg_rdata, sbus_addr, sbus_wdata;
   logic [31:0] seen_addr, seen_wd, rd_val;
   int          bad_count = 0;
   int          total_checks = 0;
   int          cyc = 0;
   int          reqs = 0;
   int          boots = 0;
   int          wt = -1;

   dfah_top u_dfah_top
   (
      .clk          (clk),
      .rst          (rst),
      .clk_en       (clk_en),
      .tck          (tck),
      .reset_n_pin  (reset_n_pin),
      .supply_ok    (supply_ok),
      .protected_st (protected_st),
      .dbg_req      (dbg_req),
      .dbg_cmd      (dbg_cmd),
      .dbg_addr     (dbg_addr),
      .dbg_wdata    (dbg_wdata),
      .dbg_ready    (dbg_ready),
      .dbg_done     (dbg_done),
      .dbg_err      (dbg_err),
      .dbg_rdata    (dbg_rdata),
      .sbus_req     (sbus_req),
      .sbus_wr      (sbus_wr),
      .sbus_addr    (sbus_addr),
      .sbus_wdata   (sbus_wdata),
      .sbus_ack     (sbus_ack),
      .sbus_rdata   (sbus_rdata),
      .slow_clk_sel (slow_clk_sel),
      .sys_rst      (sys_rst),
      .dbg_port_rst (dbg_port_rst),
      .cpu_hold_rst (cpu_hold_rst),
      .cpu_rst      (cpu_rst),
      .cpu_boot     (cpu_boot),
      .vec_catch    (vec_catch)
   );
   dfah_dbg u_dfah_dbg
   (
      .tck          (tck),
      .reset_n_pin  (reset_n_pin),
      .dbg_req      (dbg_req),
      .dbg_cmd      (dbg_cmd),
      .dbg_addr     (dbg_addr),
      .dbg_wdata    (dbg_wdata),
      .dbg_ready    (dbg_ready),
      .dbg_done     (dbg_done),
      .dbg_err      (dbg_err),
      .dbg_rdata    (dbg_rdata)
   );

   always #20 clk = ~clk;

   // Bus slave with random wait; data changes every beat
   always @(posedge clk)
   begin
      sbus_ack <= (wt == 0);
      sbus_rdata <= (wt == 0) ? rd_val : ~sbus_rdata;
      if (wt >= 0)
         wt--;
      if (sbus_req === 1'b1)
      begin
         reqs++;
         seen_wr = sbus_wr;
         seen_addr = sbus_addr;
         seen_wd = sbus_wdata;
         wt = $urandom_range(3, 0);
      end
      boots += (cpu_boot === 1'b1);
      cyc++;
      if (cyc == 20000)
      begin
         bad_count++;
         end_sim;
      end
   end

   task automatic check(input string nm, input logic [31:0] seen, exp);
      total_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   function automatic logic refused(input logic hold, prot);
      return hold | prot;
   endfunction

   function automatic logic [31:0] ctl(input logic r, v);
      return (32'(r) << `DFAH_CTRL_RELEASE) | (32'(v) << `DFAH_CTRL_VCATCH);
   endfunction

   task automatic end_sim;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // Power-up, hold, program, restart three ways
   initial
   begin
      logic        e;
      logic [1:0]  c;
      logic [31:0] d, a, w;
      int          r0;
      r0 = $urandom(32'h1297E34B);
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      supply_ok <= 1'b1;
      #1 check("por_port_rst", dbg_port_rst, 1'b1);
      repeat (8) @(posedge clk);
      #1 check("slow_clk", slow_clk_sel, 1'b1);
      check("port_rst", dbg_port_rst, 1'b0);
      check("sys_rst", sys_rst, 1'b1);
      u_dfah_dbg.strap(1'b0, 1'b1);
      repeat (8) @(posedge clk);
      #1 check("hold", cpu_hold_rst, 1'b1);
      check("sys_free", sys_rst, 1'b0);
      check("core_rst", cpu_rst, 1'b1);
      r0 = reqs;
      for (int i = 0; i < 2; i++)
      begin
         u_dfah_dbg.xfer(2'(i ^ 1), $urandom_range(32'h1FF, 0), $urandom(), e, d);
         check("hold_err", e, refused(1'b1, 1'b0));
      end
      check("hold_bus", reqs - r0, 0);
      r0 = boots;
      u_dfah_dbg.xfer(`DFAH_CMD_CTRL, 32'h0, ctl(1'b1, 1'b1), e, d);
      repeat (4) @(posedge clk);
      #1 check("ctrl_err", e, 1'b0);
      check("boot_once", boots - r0, 1);
      check("catch", vec_catch, 1'b1);
      check("core_free", cpu_rst, 1'b0);
      repeat (10)
      begin
         c = 2'($urandom_range(1, 0));
         a = $urandom();
         w = $urandom();
         rd_val = $urandom();
         @(posedge clk) protected_st <= 1'($urandom_range(1, 0));
         r0 = reqs;
         #1 u_dfah_dbg.xfer(c, a, w, e, d);
         check("run_err", e, refused(1'b0, protected_st));
         check("bus_cnt", reqs - r0, !protected_st);
         if (!protected_st)
         begin
            check("bus_addr", seen_addr, a);
            check("bus_wr", seen_wr, c[0]);
            check("bus_data", c[0] ? seen_wd : d, c[0] ? w : rd_val);
         end
      end
      @(posedge clk) protected_st <= 1'b0;
      u_dfah_dbg.xfer(`DFAH_CMD_CTRL, 32'h0, ctl(1'b0, 1'b0), e, d);
      repeat (12) @(posedge clk);
      #1 check("rehold", cpu_hold_rst, 1'b1);
      u_dfah_dbg.strap(1'b1, 1'b0);
      repeat (6) @(posedge clk);
      #1 check("pin_restart", sys_rst, 1'b1);
      u_dfah_dbg.strap(1'b1, 1'b1);
      repeat (8) @(posedge clk);
      #1 check("run_free", cpu_rst, 1'b0);
      check("no_hold", cpu_hold_rst, 1'b0);
      // Supply loss is the power-cycle restart
      @(posedge clk) supply_ok <= 1'b0;
      repeat (4) @(posedge clk);
      #1 check("power_cycle", dbg_port_rst, 1'b1);
      end_sim;
   end
endmodule

bind dfah_top dfah_chk u_chk
(
   .clk          (clk),
   .rst          (rst),
   .tck          (tck),
   .protected_st (protected_st),
   .dbg_req      (dbg_req),
   .dbg_ready    (dbg_ready),
   .dbg_done     (dbg_done),
   .sbus_req     (sbus_req),
   .slow_clk_sel (slow_clk_sel),
   .sys_rst      (sys_rst),
   .dbg_port_rst (dbg_port_rst),
   .cpu_hold_rst (cpu_hold_rst),
   .cpu_rst      (cpu_rst),
   .cpu_boot     (cpu_boot)
);
